// [dead_stop_pkg.sv]
package dead_stop_pkg;
    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ZERO_OFFSET = 8'h04;
    localparam logic [7:0] OFS_TRAVEL_MIN = 8'h08;
    localparam logic [7:0] OFS_TRAVEL_MAX = 8'h0C;
    localparam logic [7:0] OFS_WORK_MIN = 8'h10;
    localparam logic [7:0] OFS_WORK_MAX = 8'h14;
    localparam logic [7:0] OFS_PARAM_OVERRIDE = 8'h18;
    localparam logic [7:0] OFS_INT_ADDR = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_LOOP_GAIN = 8'h24;
    // field positions
    localparam int CTRL_INT_EN_BIT = 0;
    localparam int CTRL_OVR_EN_BIT = 1;
    localparam int ZO_DIR_BIT = 31;
    localparam int ZO_DEC3_BIT = 30;
    localparam int ZO_MAG_W = 24;
    localparam int ST_ERR78_BIT = 0;
    localparam int ST_REACHED_BIT = 1;
    localparam int ST_MISSED_BIT = 2;
    localparam int PCT_W = 7;
    localparam int ADDR_W = 16;
    localparam int GAIN_W = 16;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_GAIN = 16'h0001;
    localparam logic [6:0] FULL_SPEED_PCT = 7'h64;
    // fixed figures of the dead-stop behaviour
    localparam logic [47:0] FOLLOW_HIT_FACTOR = 48'h0000_0000_0004;
    localparam logic [47:0] FOLLOW_MISS_FACTOR = 48'h0000_0000_0005;
    localparam logic [31:0] DEC2_TO_DEC3 = 32'h0000_000A;
    localparam logic [1:0] TASK_FIRST = 2'h1;
    localparam logic [1:0] ADV_NEXT = 2'h1;
    localparam logic [1:0] ADV_SKIP = 2'h2;
    localparam int BLANK_TIME_MS = 20;
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int BLANK_CYCLES = BLANK_TIME_MS * CLK_FREQ_KHZ;
    localparam int BLANK_W = 22;

    typedef enum logic [1:0] {
        CMD_TORQUE_LIMIT = 2'b00,
        CMD_DS_ABS = 2'b01,
        CMD_DS_INC = 2'b10,
        CMD_OVERRIDE = 2'b11
    } cmd_kind_type;

    // arg: torque [15:8] approach, [7:0] hold; abs target; inc distance;
    // override percent in [6:0]
    typedef struct packed {
        cmd_kind_type kind;
        logic [31:0] arg;
    } prog_cmd_type;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_BLANK = 2'b01,
        DS_SEEK = 2'b10
    } ds_state_type;
endpackage

// [dead_stop_positioning_supervisor.sv]
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module dead_stop_positioning_supervisor
    import dead_stop_pkg::*;
#(
    parameter int BLANK_COUNT = BLANK_CYCLES // shorten for simulation
) (
    input wire logic clk, // 125 MHz
    input wire logic rst, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic cmd_valid, // one-cycle program command strobe
    input wire prog_cmd_type cmd, // program command
    input wire logic signed [31:0] act_pos, // actual position
    input wire logic [31:0] cmd_speed, // commanded speed
    input wire logic [31:0] follow_err, // following error magnitude
    input wire logic follow_fault, // drive cannot follow
    input wire logic auto_mode, // automatic mode on
    input wire logic homing, // homing cycle running
    input wire logic [1:0] task_id, // running program task
    input wire logic in_rts_sub, // inside return-closed subprogram
    input wire logic int_event, // external switching signal pulse
    output logic advance_valid, // block advance pulse
    output logic [1:0] advance_by, // blocks to advance
    output logic jump_valid, // interrupt jump pulse
    output logic [ADDR_W-1:0] jump_addr, // interrupt target block
    output logic [7:0] torque_limit, // active torque limit percent
    output logic torque_active, // torque limit in force
    output logic error78, // drive error 78 sticky
    output logic [PCT_W-1:0] override_pct, // effective speed percent
    output logic signed [31:0] work_min, // working range low
    output logic signed [31:0] work_max // working range high
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_r;
    logic [31:0] zero_ofs_r;
    logic signed [31:0] travel_min_r;
    logic signed [31:0] travel_max_r;
    logic [PCT_W-1:0] param_ovr_r;
    logic [ADDR_W-1:0] int_addr_r;
    logic [GAIN_W-1:0] gain_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic err78_r;
    logic reached_r;
    logic missed_r;
    ds_state_type state_r;
    ds_state_type state_nxt;
    logic [BLANK_W-1:0] blank_r;
    logic signed [31:0] start_pos_r;
    logic [31:0] path_r;
    logic [7:0] tq_approach_r;
    logic [7:0] tq_hold_r;
    logic tq_set_r;
    logic at_stop_r;
    logic prog_ovr_valid_r;
    logic [PCT_W-1:0] prog_ovr_r;
    logic adv_valid_r;
    logic [1:0] adv_by_r;
    logic jump_valid_r;
    logic [ADDR_W-1:0] jump_addr_r;
    logic [7:0] torque_r;
    logic torque_act_r;
    logic [PCT_W-1:0] ovr_r;
    logic signed [31:0] work_min_r;
    logic signed [31:0] work_max_r;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic access = psel && penable;
    wire logic wr_en = access && pready_r && pwrite;
    wire logic wr_ctrl = wr_en && paddr == OFS_CTRL;
    wire logic wr_zero = wr_en && paddr == OFS_ZERO_OFFSET;
    wire logic wr_tmin = wr_en && paddr == OFS_TRAVEL_MIN;
    wire logic wr_tmax = wr_en && paddr == OFS_TRAVEL_MAX;
    wire logic wr_povr = wr_en && paddr == OFS_PARAM_OVERRIDE;
    wire logic wr_iadr = wr_en && paddr == OFS_INT_ADDR;
    wire logic wr_stat = wr_en && paddr == OFS_STATUS;
    wire logic wr_gain = wr_en && paddr == OFS_LOOP_GAIN;
    wire logic [31:0] status_word = {27'h0, state_r, missed_r, reached_r,
        err78_r};
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL: rd_word = ctrl_r;
            OFS_ZERO_OFFSET: rd_word = zero_ofs_r;
            OFS_TRAVEL_MIN: rd_word = travel_min_r;
            OFS_TRAVEL_MAX: rd_word = travel_max_r;
            OFS_WORK_MIN: rd_word = work_min_r;
            OFS_WORK_MAX: rd_word = work_max_r;
            OFS_PARAM_OVERRIDE: rd_word = {25'h0, param_ovr_r};
            OFS_INT_ADDR: rd_word = {16'h0, int_addr_r};
            OFS_STATUS: rd_word = status_word;
            OFS_LOOP_GAIN: rd_word = {16'h0, gain_r};
            default: begin
                rd_word = RST_WORD;
                rd_hit = 1'b0;
            end
        endcase
    end

    // one wait state: ready and data come from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= RST_WORD;
        end else begin
            pready_r <= access && !pready_r;
            pslverr_r <= access && !pready_r && !rd_hit;
            prdata_r <= (access && !pready_r) ? rd_word : RST_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= RST_WORD;
            zero_ofs_r <= RST_WORD;
            travel_min_r <= RST_WORD;
            travel_max_r <= RST_WORD;
            param_ovr_r <= FULL_SPEED_PCT;
            int_addr_r <= RST_WORD[ADDR_W-1:0];
            gain_r <= RST_GAIN;
        end else begin
            if (wr_ctrl) ctrl_r <= pwdata;
            if (wr_zero) zero_ofs_r <= pwdata;
            if (wr_tmin) travel_min_r <= pwdata;
            if (wr_tmax) travel_max_r <= pwdata;
            if (wr_povr) param_ovr_r <= pwdata[PCT_W-1:0];
            if (wr_iadr) int_addr_r <= pwdata[ADDR_W-1:0];
            if (wr_gain) gain_r <= pwdata[GAIN_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working range; limits stay relative to reference, offset shifts them
    wire logic [31:0] ofs_mag_raw = {8'h0, zero_ofs_r[ZO_MAG_W-1:0]};
    wire logic [31:0] ofs_mag = zero_ofs_r[ZO_DEC3_BIT] ? ofs_mag_raw :
        32'(ofs_mag_raw * DEC2_TO_DEC3);
    wire logic signed [31:0] ofs_signed = zero_ofs_r[ZO_DIR_BIT] ?
        $signed(ofs_mag) : -$signed(ofs_mag);
    wire logic signed [31:0] work_min_nxt = travel_min_r + ofs_signed;
    wire logic signed [31:0] work_max_nxt = travel_max_r + ofs_signed;

    ////////////////////////////////////////////////////////////////////////
    // dead-stop supervision; products avoid a divider for speed/gain
    wire logic ds_cmd = cmd_valid &&
        (cmd.kind == CMD_DS_ABS || cmd.kind == CMD_DS_INC);
    wire logic tq_cmd = cmd_valid && cmd.kind == CMD_TORQUE_LIMIT;
    wire logic signed [31:0] to_target = $signed(cmd.arg) - act_pos;
    wire logic [31:0] path_nxt = (cmd.kind == CMD_DS_ABS) ?
        (to_target[31] ? 32'(-to_target) : to_target) :
        (cmd.arg[31] ? 32'(-$signed(cmd.arg)) : cmd.arg);
    wire logic signed [31:0] moved_s = act_pos - start_pos_r;
    wire logic [31:0] moved = moved_s[31] ? 32'(-moved_s) : moved_s;
    wire logic [31:0] excess = (moved > path_r) ? moved - path_r : RST_WORD;
    wire logic [47:0] err_scaled = follow_err * gain_r;
    wire logic [47:0] exc_scaled = excess * gain_r;
    wire logic [47:0] speed_w = {16'h0, cmd_speed};
    wire logic stop_hit = err_scaled >= speed_w * FOLLOW_HIT_FACTOR;
    wire logic stop_miss = moved > path_r &&
        exc_scaled >= speed_w * FOLLOW_MISS_FACTOR;
    wire logic blank_done = blank_r == BLANK_W'(BLANK_COUNT - 1);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DS_IDLE: if (ds_cmd) state_nxt = DS_BLANK;
            DS_BLANK: if (blank_done) state_nxt = DS_SEEK;
            DS_SEEK: if (stop_hit || stop_miss) state_nxt = DS_IDLE;
            default: state_nxt = DS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= DS_IDLE;
            blank_r <= '0;
        end else begin
            state_r <= state_nxt;
            blank_r <= (state_r == DS_BLANK) ? blank_r + 1'b1 : '0;
        end
    end

    // a new command while one runs is ignored until it resolves
    always_ff @(posedge clk) begin
        if (rst) begin
            start_pos_r <= RST_WORD;
            path_r <= RST_WORD;
        end else if (ds_cmd && state_r == DS_IDLE) begin
            start_pos_r <= act_pos;
            path_r <= path_nxt;
        end
    end

    wire logic seek_hit = state_r == DS_SEEK && stop_hit;
    wire logic seek_miss = state_r == DS_SEEK && !stop_hit && stop_miss;
    wire logic [1:0] adv_nxt = seek_hit ? ADV_SKIP : ADV_NEXT;

    always_ff @(posedge clk) begin
        if (rst) begin
            adv_valid_r <= 1'b0;
            adv_by_r <= 2'h0;
        end else begin
            adv_valid_r <= seek_hit || seek_miss;
            adv_by_r <= (seek_hit || seek_miss) ? adv_nxt : 2'h0;
        end
    end

    // torque: approach limit in the run, hold limit once at the stop
    always_ff @(posedge clk) begin
        if (rst) begin
            tq_approach_r <= 8'h00;
            tq_hold_r <= 8'h00;
            tq_set_r <= 1'b0;
            at_stop_r <= 1'b0;
        end else begin
            if (tq_cmd) begin
                tq_approach_r <= cmd.arg[15:8];
                tq_hold_r <= cmd.arg[7:0];
                tq_set_r <= 1'b1;
            end
            if (tq_cmd || (ds_cmd && state_r == DS_IDLE)) at_stop_r <= 1'b0;
            else if (seek_hit) at_stop_r <= 1'b1;
        end
    end

    wire logic tq_run = tq_set_r && state_r != DS_IDLE;
    wire logic err78_set = tq_run && follow_fault;
    always_ff @(posedge clk) begin
        if (rst) begin
            err78_r <= 1'b0;
            reached_r <= 1'b0;
            missed_r <= 1'b0;
            torque_r <= 8'h00;
            torque_act_r <= 1'b0;
        end else begin
            // set wins over a write-one clear in the same cycle
            err78_r <= err78_set ||
                (err78_r && !(wr_stat && pwdata[ST_ERR78_BIT]));
            reached_r <= seek_hit ||
                (reached_r && !(wr_stat && pwdata[ST_REACHED_BIT]));
            missed_r <= seek_miss ||
                (missed_r && !(wr_stat && pwdata[ST_MISSED_BIT]));
            torque_r <= at_stop_r ? tq_hold_r : tq_approach_r;
            torque_act_r <= tq_set_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt vector; no return address is kept on purpose
    wire logic int_take = int_event && ctrl_r[CTRL_INT_EN_BIT] &&
        auto_mode && task_id == TASK_FIRST && !in_rts_sub;
    always_ff @(posedge clk) begin
        if (rst) begin
            jump_valid_r <= 1'b0;
            jump_addr_r <= RST_WORD[ADDR_W-1:0];
        end else begin
            jump_valid_r <= int_take;
            if (int_take) jump_addr_r <= int_addr_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speed override
    wire logic ovr_cmd = cmd_valid && cmd.kind == CMD_OVERRIDE;
    wire logic [PCT_W-1:0] ovr_nxt = homing ? FULL_SPEED_PCT :
        prog_ovr_valid_r ? prog_ovr_r :
        ctrl_r[CTRL_OVR_EN_BIT] ? param_ovr_r : FULL_SPEED_PCT;
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_ovr_valid_r <= 1'b0;
            prog_ovr_r <= FULL_SPEED_PCT;
            ovr_r <= FULL_SPEED_PCT;
            work_min_r <= RST_WORD;
            work_max_r <= RST_WORD;
        end else begin
            if (!auto_mode) prog_ovr_valid_r <= 1'b0;
            else if (ovr_cmd) prog_ovr_valid_r <= 1'b1;
            if (ovr_cmd && auto_mode) prog_ovr_r <= cmd.arg[PCT_W-1:0];
            ovr_r <= ovr_nxt;
            work_min_r <= work_min_nxt;
            work_max_r <= work_max_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign advance_valid = adv_valid_r;
    assign advance_by = adv_by_r;
    assign jump_valid = jump_valid_r;
    assign jump_addr = jump_addr_r;
    assign torque_limit = torque_r;
    assign torque_active = torque_act_r;
    assign error78 = err78_r;
    assign override_pct = ovr_r;
    assign work_min = work_min_r;
    assign work_max = work_max_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_hit_skips: assert property (
        seek_hit |=> advance_valid && advance_by == ADV_SKIP)
        else $error("stop hit did not skip a block");
    a_miss_next: assert property (
        seek_miss |=> advance_valid && advance_by == ADV_NEXT)
        else $error("missed stop did not advance one block");
    a_blank_hold: assert property (
        state_r == DS_IDLE && ds_cmd |=> (state_r == DS_BLANK) [*8])
        else $error("recognition opened inside blanking time");
    a_no_adv_blank: assert property (
        state_r == DS_BLANK |=> !advance_valid)
        else $error("block advanced during blanking");
    a_hit_factor: assert property (
        state_r == DS_SEEK && 48'(follow_err) * gain_r <
        {16'h0, cmd_speed} * FOLLOW_HIT_FACTOR |=> advance_by != ADV_SKIP)
        else $error("stop declared below fourfold error");
    a_err78_set: assert property (
        tq_run && follow_fault |=> error78)
        else $error("error 78 not raised");
    a_int_task: assert property (
        jump_valid |-> $past(task_id) == TASK_FIRST && !$past(in_rts_sub))
        else $error("interrupt jump outside first task");
    a_int_take: assert property (
        int_take |=> jump_valid && jump_addr == $past(int_addr_r))
        else $error("enabled interrupt not taken");
    a_homing_ovr: assert property (
        homing |=> override_pct == FULL_SPEED_PCT)
        else $error("override applied while homing");
    a_prog_prio: assert property (
        prog_ovr_valid_r && !homing |=> override_pct == $past(prog_ovr_r))
        else $error("program override lost priority");
    a_work_range: assert property (
        $stable(zero_ofs_r) && $stable(travel_min_r) |=>
        work_min == $past(travel_min_r) + $past(ofs_signed))
        else $error("working range low not shifted by offset");

    c_hit: cover property (seek_hit ##1 advance_valid);
    c_miss: cover property (seek_miss ##1 advance_valid);
    c_int: cover property (int_take ##1 jump_valid);
    c_err78: cover property (err78_set ##1 error78);

endmodule // dead_stop_positioning_supervisor

// [dead_stop_positioning_supervisor_pad.sv]
`timescale 1ns/1ns

// [servo_model.sv]
`timescale 1ns/1ns
module servo_model #(
    parameter int SPEED = 4 // commanded speed while running
) (
    input wire logic clk, // controller clock
    input wire logic rst, // synchronous, active high
    input wire logic run, // axis commanded to move
    input wire logic blocked, // axis pressed against the stop
    input wire logic fault_req, // drive loses the ability to follow
    output logic signed [31:0] act_pos, // actual position
    output logic [31:0] cmd_speed, // commanded speed
    output logic [31:0] follow_err, // following error magnitude
    output logic follow_fault // drive cannot follow
);
    assign cmd_speed = run ? 32'(SPEED) : 32'h0;
    assign follow_fault = run & fault_req;
    // a blocked axis cannot close its lag, so the error keeps growing
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            follow_err <= 32'h0;
        end else if (blocked) begin
            follow_err <= follow_err + 32'h2;
        end else begin
            follow_err <= 32'(SPEED);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            act_pos <= 32'h0;
        end else if (run && !blocked) begin
            act_pos <= act_pos + 32'h1;
        end
    end
endmodule // servo_model

// [testbench.sv]
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin checks_done++; \
    if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module testbench;
    import dead_stop_pkg::*;
    localparam int BLANK = 16;
    localparam logic signed [31:0] TMIN = 32'hFFFC_F2C0;
    localparam logic signed [31:0] TMAX = 32'h000F_4240;
    localparam logic [31:0] ZO [3] = '{32'h0000_3A98, 32'hC002_49F0, 32'h0};
    // expected hits, enable, auto, task, subprogram
    localparam logic [5:0] IRQ [5] = '{6'h0A, 6'h3A, 6'h1C, 6'h1B, 6'h12};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_valid = 1'b0;
    prog_cmd_type cmd = '0;
    logic signed [31:0] act_pos;
    logic [31:0] cmd_speed;
    logic [31:0] follow_err;
    logic follow_fault;
    logic auto_mode = 1'b0;
    logic homing = 1'b0;
    logic [1:0] task_id = 2'h1;
    logic in_rts_sub = 1'b0;
    logic int_event = 1'b0;
    logic advance_valid;
    logic [1:0] advance_by;
    logic jump_valid;
    logic [ADDR_W-1:0] jump_addr;
    logic [7:0] torque_limit;
    logic torque_active;
    logic error78;
    logic [PCT_W-1:0] override_pct;
    logic signed [31:0] work_min;
    logic signed [31:0] work_max;
    logic run = 1'b0;
    logic blocked = 1'b0;
    logic fault_req = 1'b0;
    int n_fail = 0;
    int checks_done = 0;
    int cnt;
    int hits;
    logic [31:0] q;
    logic e;
    logic [1:0] by;
    logic [31:0] zo;
    logic signed [31:0] mag;
    logic signed [31:0] emin;
    logic signed [31:0] emax;

    dead_stop_positioning_supervisor #(.BLANK_COUNT(BLANK)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
        .cmd(cmd), .act_pos(act_pos), .cmd_speed(cmd_speed),
        .follow_err(follow_err), .follow_fault(follow_fault),
        .auto_mode(auto_mode), .homing(homing), .task_id(task_id),
        .in_rts_sub(in_rts_sub), .int_event(int_event),
        .advance_valid(advance_valid), .advance_by(advance_by),
        .jump_valid(jump_valid), .jump_addr(jump_addr),
        .torque_limit(torque_limit), .torque_active(torque_active),
        .error78(error78), .override_pct(override_pct),
        .work_min(work_min), .work_max(work_max));
    servo_model u_drive (
        .clk(clk), .rst(rst), .run(run), .blocked(blocked),
        .fault_req(fault_req), .act_pos(act_pos), .cmd_speed(cmd_speed),
        .follow_err(follow_err), .follow_fault(follow_fault));

    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic time_out();
        n_fail++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask
    // caller stands just after a rising edge; one edge passes on release
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rq, output logic re);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) time_out();
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, q, e);
        `CHK({e, q}, {1'b0, x}, "register read")
    endtask
    task automatic send_cmd(input cmd_kind_type k, input logic [31:0] arg);
        cmd_valid <= 1'b1;
        cmd <= '{k, arg};
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_adv(input int lim);
        cnt = 0;
        while (advance_valid !== 1'b1) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) time_out();
        end
        by = advance_by;
    endtask
    task automatic pulse_int();
        hits = 0;
        int_event <= 1'b1;
        @(posedge clk);
        int_event <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (jump_valid === 1'b1) hits++;
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(override_pct, FULL_SPEED_PCT, "reset speed")
        rd_chk(OFS_CTRL, RST_WORD);
        rd_chk(OFS_PARAM_OVERRIDE, 32'h0000_0064);
        rd_chk(OFS_LOOP_GAIN, {16'h0000, RST_GAIN});
        apb(1'b0, 8'h40, 32'h0, q, e);
        `CHK({e, q}, 33'h1_0000_0000, "unmapped read")
        $display("test registers done");
        wr(OFS_TRAVEL_MIN, TMIN);
        wr(OFS_TRAVEL_MAX, TMAX);
        for (int i = 0; i < 3; i++) begin
            zo = ZO[i];
            mag = 32'(zo[ZO_MAG_W-1:0]) * (zo[ZO_DEC3_BIT] ? 1 : 10);
            emin = zo[ZO_DIR_BIT] ? TMIN + mag : TMIN - mag;
            emax = zo[ZO_DIR_BIT] ? TMAX + mag : TMAX - mag;
            wr(OFS_ZERO_OFFSET, zo);
            wr(OFS_WORK_MIN, 32'h0);
            `CHK(work_min, emin, "range low")
            `CHK(work_max, emax, "range high")
            rd_chk(OFS_WORK_MIN, emin);
        end
        $display("test working range done");
        send_cmd(CMD_TORQUE_LIMIT, 32'h0000_3C14);
        // the torque outputs trail the command strobe by two edges
        @(posedge clk);
        `CHK({torque_active, torque_limit}, 9'h13C, "approach torque")
        run <= 1'b1;
        blocked <= 1'b1;
        send_cmd(CMD_DS_INC, 32'h0000_1000);
        wait_adv(64);
        `CHK(by, ADV_SKIP, "skip on stop")
        `CHK(cnt >= BLANK - 1 && cnt <= BLANK + 4, 1'b1, "blanking")
        repeat (2) @(posedge clk);
        `CHK(torque_limit, 8'h14, "hold torque")
        `CHK(error78, 1'b0, "false drive error")
        rd_chk(OFS_STATUS, 32'h0000_0002);
        run <= 1'b0;
        blocked <= 1'b0;
        wr(OFS_STATUS, 32'h0000_0007);
        // a higher gain scales up the excess travel, so the miss comes sooner
        for (int g = 1; g <= 2; g++) begin
            wr(OFS_LOOP_GAIN, 32'(g));
            run <= 1'b1;
            send_cmd(CMD_DS_INC, 32'h0000_000A);
            wait_adv(80);
            run <= 1'b0;
            `CHK(by, ADV_NEXT, "next on miss")
            `CHK(cnt >= 7 + 20 / g && cnt <= 15 + 20 / g, 1'b1,
                "miss distance")
            rd_chk(OFS_STATUS, 32'h0000_0004);
            wr(OFS_STATUS, 32'h0000_0007);
        end
        run <= 1'b1;
        fault_req <= 1'b1;
        // absolute target far past the stop, so only the stop ends the run
        send_cmd(CMD_DS_ABS, 32'h0000_1000);
        repeat (2) @(posedge clk);
        `CHK(error78, 1'b1, "drive error")
        fault_req <= 1'b0;
        blocked <= 1'b1;
        wait_adv(64);
        run <= 1'b0;
        blocked <= 1'b0;
        rd_chk(OFS_STATUS, 32'h0000_0003);
        wr(OFS_STATUS, 32'h0000_0007);
        $display("test dead stop done");
        wr(OFS_INT_ADDR, 32'h0000_0123);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, {31'h0, IRQ[i][4]});
            auto_mode <= IRQ[i][3];
            task_id <= IRQ[i][2:1];
            in_rts_sub <= IRQ[i][0];
            @(posedge clk);
            pulse_int();
            `CHK(hits, IRQ[i][5], "jump count")
        end
        `CHK(jump_addr, 16'h0123, "jump target")
        $display("test interrupt done");
        wr(OFS_PARAM_OVERRIDE, 32'h0000_0032);
        wr(OFS_CTRL, 32'h0000_0002);
        auto_mode <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(override_pct, 7'h32, "parameter speed")
        send_cmd(CMD_OVERRIDE, 32'h0000_001E);
        wr(OFS_PARAM_OVERRIDE, 32'h0000_0028);
        `CHK(override_pct, 7'h1E, "program speed first")
        homing <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(override_pct, FULL_SPEED_PCT, "homing speed")
        homing <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(override_pct, 7'h1E, "program speed kept")
        auto_mode <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(override_pct, 7'h28, "program speed dropped")
        $display("test override done");
        wrap_up();
    end
endmodule // testbench
